/* File: hw/readback_pkg.sv */
package readback_pkg;

    // frame geometry
    localparam int WORD_BITS = 24;
    localparam int DATA_BITS = 16;
    localparam int PAD_BITS = WORD_BITS - DATA_BITS;
    localparam int CHANNELS = 4;

    // input word field positions
    localparam int RW_BIT = 23;
    localparam int ADDR_HI_BIT = 22;
    localparam int ADDR_LO_BIT = 21;
    localparam int SEL_MSB = 20;
    localparam int SEL_LSB = 16;

    // no-operation word body below the two address bits
    localparam logic [20:0] NOP_BODY = 21'h1ce000;

    // bit counter value of a complete word
    localparam logic [4:0] BIT_CNT_FULL = 5'h18;
    localparam logic [4:0] BIT_CNT_MAX = 5'h1f;

    // read select groups (upper three bits of the selector)
    localparam logic [2:0] GRP_DATA = 3'h0;
    localparam logic [2:0] GRP_CTRL = 3'h1;
    localparam logic [2:0] GRP_GAIN = 3'h2;
    localparam logic [2:0] GRP_OFFSET = 3'h3;
    localparam logic [2:0] GRP_CLEAR = 3'h4;
    localparam logic [2:0] GRP_SLEW = 3'h5;

    // single register select codes
    localparam logic [4:0] SEL_STATUS = 5'h18;
    localparam logic [4:0] SEL_MAIN_CTRL = 5'h19;
    localparam logic [4:0] SEL_DCDC_CTRL = 5'h1a;

    // slew control word field positions
    localparam int SLEW_EN_BIT = 12;
    localparam int SLEW_RATE_LSB = 3;
    localparam int SLEW_STEP_LSB = 0;

    // per channel slew limiter setting
    typedef struct packed {
        logic enable;
        logic [3:0] update_rate;
        logic [2:0] step_size;
    } slew_cfg_t;

    localparam slew_cfg_t SLEW_RESET = '0;

    // slew register write from the device write path
    typedef struct packed {
        logic valid;
        logic [1:0] channel;
        logic [15:0] word;
    } slew_wr_t;

    // readable registers held elsewhere in the device
    typedef struct packed {
        logic [3:0][15:0] dac_data;
        logic [3:0][15:0] dac_ctrl;
        logic [3:0][15:0] gain;
        logic [3:0][15:0] offset;
        logic [3:0][15:0] clear_code;
        logic [15:0] status;
        logic [15:0] main_ctrl;
        logic [15:0] dcdc_ctrl;
    } dev_regs_t;

    // serial pins and address straps
    typedef struct packed {
        logic sclk;
        logic sync_n;
        logic sdin;
        logic device_addr_hi;
        logic device_addr_lo;
    } pins_t;

    typedef enum logic {S_IDLE, S_FRAME} frame_state_t;

endpackage : readback_pkg

/* File: hw/pin_sync.sv */
module pin_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    // pins
    input wire readback_pkg::pins_t pins_i,
    output readback_pkg::pins_t pins_o
);
    import readback_pkg::*;

    typedef struct packed {
        pins_t meta;
        pins_t sync;
    } sync_state_t;

    sync_state_t st_r;
    sync_state_t st_nxt;

    // two flops per pin, first stage read only by the second
    always_comb begin
        st_nxt = st_r;
        if (clk_en_i) begin
            st_nxt.meta = pins_i;
            st_nxt.sync = st_r.meta;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_r <= '{meta: '{sync_n: 1'b1, default: 1'b0}, sync: '{sync_n: 1'b1, default: 1'b0}};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pins_o = st_r.sync;

endmodule : pin_sync

/* File: hw/readback_mux.sv */
module readback_mux (
    // selection
    input wire logic [4:0] sel_i,
    // register sources
    input wire readback_pkg::dev_regs_t regs_i,
    input wire readback_pkg::slew_cfg_t [3:0] slew_i,
    // result
    output logic [15:0] data_o
);
    import readback_pkg::*;

    logic [3:0][15:0] slew_words;

    // slew words rebuilt with zero top bits and zero don't-care field
    generate
        for (genvar c = 0; c < CHANNELS; c++) begin : g_slew
            assign slew_words[c] = {3'h0, slew_i[c].enable, 5'h00, slew_i[c].update_rate, slew_i[c].step_size}; // RULE_14
        end
    endgenerate

    // group select on upper bits, channel in the low two bits
    always_comb begin
        data_o = 16'h0000;
        case (sel_i[4:2])
            GRP_DATA: data_o = regs_i.dac_data[sel_i[1:0]]; // RULE_11
            GRP_CTRL: data_o = regs_i.dac_ctrl[sel_i[1:0]]; // RULE_11
            GRP_GAIN: data_o = regs_i.gain[sel_i[1:0]]; // RULE_11
            GRP_OFFSET: data_o = regs_i.offset[sel_i[1:0]]; // RULE_11
            GRP_CLEAR: data_o = regs_i.clear_code[sel_i[1:0]]; // RULE_12
            GRP_SLEW: data_o = slew_words[sel_i[1:0]]; // RULE_12
            default: begin
                if (sel_i == SEL_STATUS) begin
                    data_o = regs_i.status; // RULE_13
                end else if (sel_i == SEL_MAIN_CTRL) begin
                    data_o = regs_i.main_ctrl; // RULE_13
                end else if (sel_i == SEL_DCDC_CTRL) begin
                    data_o = regs_i.dcdc_ctrl; // RULE_13
                end else begin
                    data_o = 16'h0000;
                end
            end
        endcase
    end

endmodule : readback_mux

/* File: hw/serial_register_readback.sv */
// Behaviour
// RULE_01: a word with top bit D23 set is a readback request, not a write.
// RULE_02: device address bits D22..D21 plus selector D20..D16 choose the register.
// RULE_03: the low sixteen bits of a readback request are ignored.
// RULE_04: the next transfer shifts the previously selected register out on serial out.
// RULE_05: host follows a request with another request or a no-operation word.
// RULE_06: no-operation word 0x1CE000 with address bits set alters no register.
// RULE_07: returned data sits in the sixteen low bits of the output frame.
// RULE_08: first clock edge rising gives eight pad bits then sixteen data bits.
// RULE_09: first clock edge falling gives seven pad bits then sixteen data bits.
// RULE_10: with packet checking on, host keeps serial clock idle between request and no-op.
// RULE_11: codes 0..15 pick data, control, gain, offset registers, channel in low bits.
// RULE_12: codes 16..19 pick clear-code registers, 20..23 slew control registers.
// RULE_13: code 24 status, 25 main control, 26 boost converter control.
// RULE_14: slew word holds enable at 12, update rate 6..3, step size 2..0.
// RULE_15: slew limiting is set per channel and covers current and voltage outputs.
// RULE_16: with status-on-every-write clear, status only comes back by readback request.
// RULE_17: fields captured at frame end of a full 24-bit word; foreign addresses ignored.
module serial_register_readback (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    // serial pins and address straps
    input wire logic sclk_i,
    input wire logic sync_n_i,
    input wire logic sdin_i,
    input wire logic device_addr_hi_i,
    input wire logic device_addr_lo_i,
    output logic sdo_o,
    // register contents of the device
    input wire readback_pkg::dev_regs_t regs_i,
    input wire logic status_on_every_write_i,
    // slew register write port and settings
    input wire readback_pkg::slew_wr_t slew_wr_i,
    output readback_pkg::slew_cfg_t [3:0] slew_cfg_o,
    // received write words for the device write path
    output logic word_valid_o,
    output logic [23:0] word_o,
    output logic read_pending_o
);
    import readback_pkg::*;

    typedef struct packed {
        frame_state_t state;
        logic sclk_q;
        logic sync_q;
        logic [4:0] bit_cnt;
        logic [23:0] in_sr;
        logic [23:0] out_sr;
        logic pend_valid;
        logic [4:0] pend_sel;
        logic word_valid;
        logic [23:0] word;
        slew_cfg_t [3:0] slew;
    } main_state_t;

    main_state_t st_r;
    main_state_t st_nxt;
    pins_t pins_raw;
    pins_t pins_s;
    logic [15:0] rb_data;
    logic sync_fall;
    logic sync_rise;
    logic sclk_fall;
    logic addr_match;
    logic is_nop;

    assign pins_raw = '{sclk: sclk_i, sync_n: sync_n_i, sdin: sdin_i,
                        device_addr_hi: device_addr_hi_i, device_addr_lo: device_addr_lo_i};

    pin_sync u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .pins_i(pins_raw),
        .pins_o(pins_s)
    );

    readback_mux u_mux (
        .sel_i(st_r.pend_sel),
        .regs_i(regs_i),
        .slew_i(st_r.slew),
        .data_o(rb_data)
    );

    // edges of the synchronised pins, and decode of the received word
    assign sync_fall = st_r.sync_q & ~pins_s.sync_n;
    assign sync_rise = ~st_r.sync_q & pins_s.sync_n;
    assign sclk_fall = st_r.sclk_q & ~pins_s.sclk;
    assign addr_match = (st_r.in_sr[ADDR_HI_BIT] == pins_s.device_addr_hi) &&
                        (st_r.in_sr[ADDR_LO_BIT] == pins_s.device_addr_lo); // RULE_17
    assign is_nop = ~st_r.in_sr[RW_BIT] && (st_r.in_sr[20:0] == NOP_BODY); // RULE_06

    // frame engine: sample on falling sclk, advance serial out on falling sclk
    always_comb begin
        st_nxt = st_r;
        if (clk_en_i) begin
            st_nxt.word_valid = 1'b0;
            st_nxt.sclk_q = pins_s.sclk;
            st_nxt.sync_q = pins_s.sync_n;
            if (slew_wr_i.valid) begin
                // each channel holds its own limiter setting
                st_nxt.slew[slew_wr_i.channel].enable = slew_wr_i.word[SLEW_EN_BIT]; // RULE_14 RULE_15
                st_nxt.slew[slew_wr_i.channel].update_rate = slew_wr_i.word[SLEW_RATE_LSB +: 4]; // RULE_14
                st_nxt.slew[slew_wr_i.channel].step_size = slew_wr_i.word[SLEW_STEP_LSB +: 3]; // RULE_14
            end
            case (st_r.state)
                S_IDLE: begin
                    if (sync_fall) begin
                        st_nxt.state = S_FRAME;
                        st_nxt.bit_cnt = 5'h00;
                        st_nxt.in_sr = 24'h000000;
                        st_nxt.pend_valid = 1'b0;
                        if (st_r.pend_valid) begin
                            // pad bits read as zero ahead of the data
                            st_nxt.out_sr = {{PAD_BITS{1'b0}}, rb_data}; // RULE_04 RULE_07
                        end else if (status_on_every_write_i) begin
                            st_nxt.out_sr = {{PAD_BITS{1'b0}}, regs_i.status};
                        end else begin
                            st_nxt.out_sr = 24'h000000; // RULE_16
                        end
                    end
                end
                S_FRAME: begin
                    if (sync_rise) begin
                        st_nxt.state = S_IDLE;
                        if (st_r.bit_cnt == BIT_CNT_FULL && addr_match) begin // RULE_17
                            if (st_r.in_sr[RW_BIT]) begin
                                // only the selector is kept, low sixteen bits dropped
                                st_nxt.pend_valid = 1'b1; // RULE_01
                                st_nxt.pend_sel = st_r.in_sr[SEL_MSB:SEL_LSB]; // RULE_02 RULE_03
                            end else if (!is_nop) begin
                                st_nxt.word_valid = 1'b1; // RULE_06
                                st_nxt.word = st_r.in_sr;
                            end
                        end
                    end else if (sclk_fall) begin
                        // a rising first edge lets the host see bit 23; a falling one skips it
                        st_nxt.in_sr = {st_r.in_sr[22:0], pins_s.sdin};
                        st_nxt.out_sr = {st_r.out_sr[22:0], 1'b0}; // RULE_08 RULE_09
                        if (st_r.bit_cnt != BIT_CNT_MAX) begin
                            st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
                        end
                    end
                end
                default: st_nxt.state = S_IDLE;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_r <= '{state: S_IDLE, sclk_q: 1'b0, sync_q: 1'b1, bit_cnt: 5'h00, in_sr: 24'h000000,
                      out_sr: 24'h000000, pend_valid: 1'b0, pend_sel: 5'h00, word_valid: 1'b0,
                      word: 24'h000000, slew: {CHANNELS{SLEW_RESET}}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from state flops
    assign sdo_o = st_r.out_sr[WORD_BITS-1];
    assign slew_cfg_o = st_r.slew;
    assign word_valid_o = st_r.word_valid;
    assign word_o = st_r.word;
    assign read_pending_o = st_r.pend_valid;

    // checks on the frame engine
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    logic word_end;
    assign word_end = clk_en_i && st_r.state == S_FRAME && sync_rise && st_r.bit_cnt == BIT_CNT_FULL;

    // capture of requests when a word ends
    a_read_capture: assert property (word_end && st_r.in_sr[RW_BIT] && addr_match // RULE_01
        |=> st_r.pend_valid && st_r.pend_sel == $past(st_r.in_sr[SEL_MSB:SEL_LSB]))
        else $error("readback request not captured");

    a_in_shift: assert property (clk_en_i && st_r.state == S_FRAME && !sync_rise && sclk_fall // RULE_01
        |=> st_r.in_sr == {$past(st_r.in_sr[22:0]), $past(pins_s.sdin)})
        else $error("serial input bit not taken on falling edge");

    a_write_word: assert property (word_end && addr_match && !st_r.in_sr[RW_BIT] && !is_nop // RULE_01
        |=> st_r.word_valid && st_r.word == $past(st_r.in_sr))
        else $error("write word not handed on");

    a_addr_filter: assert property (word_end && !addr_match // RULE_17
        |=> !st_r.word_valid && st_r.pend_valid == $past(st_r.pend_valid))
        else $error("foreign address word acted upon");

    // words of the wrong length are dropped whole
    a_short_frame: assert property (clk_en_i && st_r.state == S_FRAME && sync_rise // RULE_17
        && st_r.bit_cnt != BIT_CNT_FULL |=> !st_r.word_valid && !st_r.pend_valid)
        else $error("incomplete word acted upon");

    a_bit_count: assert property (clk_en_i && st_r.state == S_FRAME && !sync_rise && sclk_fall // RULE_17
        && st_r.bit_cnt != BIT_CNT_MAX |=> st_r.bit_cnt == $past(st_r.bit_cnt) + 5'h01)
        else $error("falling edge not counted");

    // a slew write in the same cycle is a legal change, so it is kept out
    a_nop_quiet: assert property (word_end && is_nop && addr_match && !slew_wr_i.valid // RULE_06
        |=> !st_r.word_valid && $stable(st_r.slew) && !st_r.pend_valid)
        else $error("no-operation word changed state");

    a_word_pulse: assert property (clk_en_i && st_r.word_valid |=> !st_r.word_valid)
        else $error("write word strobe held too long");

    // loading of the output frame when a transfer starts
    a_readback_load: assert property (clk_en_i && st_r.state == S_IDLE && sync_fall && st_r.pend_valid // RULE_04
        |=> st_r.out_sr[15:0] == $past(rb_data) && st_r.out_sr[23:16] == 8'h00)
        else $error("readback data not loaded into frame");

    a_pend_consumed: assert property (clk_en_i && st_r.state == S_IDLE && sync_fall // RULE_04
        |=> st_r.state == S_FRAME && !st_r.pend_valid && st_r.bit_cnt == 5'h00)
        else $error("pending read not consumed by the next frame");

    a_status_gate: assert property (clk_en_i && st_r.state == S_IDLE && sync_fall && !st_r.pend_valid // RULE_16
        && !status_on_every_write_i |=> st_r.out_sr == 24'h000000)
        else $error("status leaked without readback request");

    a_status_every: assert property (clk_en_i && st_r.state == S_IDLE && sync_fall && !st_r.pend_valid // RULE_16
        && status_on_every_write_i |=> st_r.out_sr == {8'h00, $past(regs_i.status)})
        else $error("status not returned on a write frame");

    // shifting of the serial output
    a_shift_step: assert property (clk_en_i && st_r.state == S_FRAME && !sync_rise && sclk_fall // RULE_09
        |=> st_r.out_sr == {$past(st_r.out_sr[22:0]), 1'b0} && sdo_o == $past(st_r.out_sr[22]))
        else $error("serial out did not advance on falling edge");

    // after the eighth fall the sixteen data bits lead the register
    a_data_at_end: assert property (clk_en_i && st_r.state == S_FRAME && !sync_rise && sclk_fall // RULE_07
        && st_r.bit_cnt == 5'h07 |=> st_r.out_sr[23:8] == $past(st_r.out_sr[22:7]) && st_r.out_sr[7:0] == 8'h00)
        else $error("data bits not aligned to frame tail");

    a_hold_no_edge: assert property (clk_en_i && st_r.state == S_FRAME && !sclk_fall && !sync_rise // RULE_08
        |=> $stable(st_r.out_sr) && $stable(st_r.bit_cnt))
        else $error("serial out moved without a falling edge");

    // register select, channel in the low two selector bits
    a_mux_data: assert property (st_r.pend_sel[4:2] == GRP_DATA // RULE_11
        |-> rb_data == regs_i.dac_data[st_r.pend_sel[1:0]])
        else $error("data code returned wrong register");

    a_mux_ctrl: assert property (st_r.pend_sel[4:2] == GRP_CTRL // RULE_11
        |-> rb_data == regs_i.dac_ctrl[st_r.pend_sel[1:0]])
        else $error("control code returned wrong register");

    a_mux_gain: assert property (st_r.pend_sel[4:2] == GRP_GAIN // RULE_11
        |-> rb_data == regs_i.gain[st_r.pend_sel[1:0]])
        else $error("gain code returned wrong register");

    a_mux_offset: assert property (st_r.pend_sel[4:2] == GRP_OFFSET // RULE_11
        |-> rb_data == regs_i.offset[st_r.pend_sel[1:0]])
        else $error("offset code returned wrong register");

    a_mux_clear: assert property (st_r.pend_sel[4:2] == GRP_CLEAR // RULE_12
        |-> rb_data == regs_i.clear_code[st_r.pend_sel[1:0]])
        else $error("clear-code returned wrong register");

    a_mux_slew: assert property (st_r.pend_sel[4:2] == GRP_SLEW // RULE_12 RULE_14
        |-> rb_data[15:13] == 3'h0 && rb_data[SLEW_EN_BIT] == st_r.slew[st_r.pend_sel[1:0]].enable)
        else $error("slew code returned wrong register");

    a_mux_status: assert property (st_r.pend_sel == SEL_STATUS // RULE_13
        |-> rb_data == regs_i.status)
        else $error("status code returned wrong register");

    a_mux_main: assert property (st_r.pend_sel == SEL_MAIN_CTRL // RULE_13
        |-> rb_data == regs_i.main_ctrl)
        else $error("main control code returned wrong register");

    a_mux_dcdc: assert property (st_r.pend_sel == SEL_DCDC_CTRL // RULE_13
        |-> rb_data == regs_i.dcdc_ctrl)
        else $error("boost control code returned wrong register");

    // codes past the boost control register read as zero
    a_mux_unused: assert property (st_r.pend_sel > SEL_DCDC_CTRL |-> rb_data == 16'h0000)
        else $error("unused code returned data");

    // slew settings, one set per channel
    a_slew_write: assert property (clk_en_i && slew_wr_i.valid // RULE_14
        |=> st_r.slew[$past(slew_wr_i.channel)].enable == $past(slew_wr_i.word[SLEW_EN_BIT])
        && st_r.slew[$past(slew_wr_i.channel)].update_rate == $past(slew_wr_i.word[SLEW_RATE_LSB +: 4])
        && st_r.slew[$past(slew_wr_i.channel)].step_size == $past(slew_wr_i.word[SLEW_STEP_LSB +: 3]))
        else $error("slew setting not stored");

    generate
        for (genvar c = 0; c < CHANNELS; c++) begin : g_slew_chk
            a_slew_alone: assert property (clk_en_i && slew_wr_i.valid && slew_wr_i.channel != 2'(c) // RULE_15
                |=> $stable(st_r.slew[c]))
                else $error("slew write reached another channel");
        end
    endgenerate

    // the clock enable freezes every flop, synchronisers included
    a_clk_freeze: assert property (!clk_en_i |=> $stable(st_r) && $stable(pins_s))
        else $error("state moved while the clock enable was low");

    c_read_request: cover property (word_end && st_r.in_sr[RW_BIT] && addr_match);
    c_readback_frame: cover property (st_r.state == S_IDLE && sync_fall && st_r.pend_valid);
    c_write_word: cover property (st_r.word_valid);
    c_slew_write: cover property (slew_wr_i.valid ##1 slew_wr_i.valid);
    c_nop_frame: cover property (word_end && is_nop && addr_match);

endmodule : serial_register_readback

/* File: tb/host_spi_model.sv */
module host_spi_model (
    // clock
    input wire logic clk_i,
    // serial pins
    output logic sclk_o,
    output logic sync_n_o,
    output logic sdin_o,
    input wire logic sdo_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // each serial clock phase lasts six system clocks, above the four the device needs
    localparam int HALF = 6;

    // idle levels at time zero
    initial begin
        sclk_o = 1'b0;
        sync_n_o = 1'b1;
        sdin_o = 1'b0;
    end

    // wait n system clocks, leaving the pins to change at the falling edge
    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask : wt

    // one 24-bit frame; rise_first picks the idle level and so the first edge in the frame
    task automatic xfer(input logic [23:0] w, input logic rise_first, output logic [23:0] rx);
        rx = '0;
        sclk_o = ~rise_first;
        wt(HALF);
        sync_n_o = 1'b0;
        wt(HALF);
        // word goes out msb first, read flag first; host samples serial out on rising clock
        for (int i = 23; i >= 0; i--) begin
            sdin_o = w[i];
            if (rise_first) begin
                sclk_o = 1'b1;
                rx = {rx[22:0], sdo_i};
                wt(HALF);
                sclk_o = 1'b0;
                wt(HALF);
            end else begin
                sclk_o = 1'b0;
                wt(HALF);
                sclk_o = 1'b1;
                rx = {rx[22:0], sdo_i};
                wt(HALF);
            end
        end
        sync_n_o = 1'b1;
        sdin_o = ~sdin_o; // stale data bit never lingers between frames
        // serial clock stays still until the next frame
        wt(2 * HALF);
    endtask : xfer
endmodule : host_spi_model

/* File: tb/serial_register_readback_tb.sv */
module serial_register_readback_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import readback_pkg::*;

    logic clk, rst, en, sclk, sync_n, sdin, sdo, soew, wvalid, pend;
    logic [1:0] strap;
    logic [23:0] word, rx, last_word;
    dev_regs_t regs;
    slew_wr_t swr;
    slew_cfg_t [3:0] cfg;
    int failures, total_checks, nvalid;
    logic [15:0] ref_val [32];
    // slew words with the don't-care bits set, to see them read back as zero
    localparam logic [15:0] SW [4] = '{16'h1fff, 16'h0f85, 16'h1fb3, 16'h0f80};

    // device under test and the host on its serial pins
    serial_register_readback u_dut (.clk_i(clk), .sys_rst_i(rst), .clk_en_i(en), .sclk_i(sclk),
        .sync_n_i(sync_n), .sdin_i(sdin), .device_addr_hi_i(strap[1]), .device_addr_lo_i(strap[0]),
        .sdo_o(sdo), .regs_i(regs), .status_on_every_write_i(soew), .slew_wr_i(swr),
        .slew_cfg_o(cfg), .word_valid_o(wvalid), .word_o(word), .read_pending_o(pend));
    host_spi_model u_host (.clk_i(clk), .sclk_o(sclk), .sync_n_o(sync_n), .sdin_o(sdin), .sdo_i(sdo));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // count write word pulses
    always @(posedge clk) begin
        if (wvalid === 1'b1) begin
            nvalid <= nvalid + 1;
            last_word <= word;
        end
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    // expected readback for a select code; slew words lose their fixed and don't-care bits
    function automatic logic [15:0] expect_of(input int code);
        if (code >= 20 && code <= 23) begin
            return SW[code - 20] & 16'h107f;
        end
        return ref_val[code];
    endfunction : expect_of

    // data field of a received frame: 24-bit frame or 23-bit frame shifted by one
    function automatic logic [23:0] pick(input logic [23:0] r, input logic rise_first);
        return rise_first ? {8'h00, r[15:0]} : {8'h00, r[16:1]};
    endfunction : pick

    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        summarize();
    end

    // main sequence
    initial begin
        failures = 0;
        total_checks = 0;
        nvalid = 0;
        last_word = '0;
        rst = 1'b1;
        strap = 2'b01;
        en = 1'b1;
        soew = 1'b0;
        swr = '0;
        for (int i = 0; i < 32; i++) begin
            ref_val[i] = (i < 27) ? (16'h8000 ^ (16'(i) * 16'h0a51)) : 16'h0000;
        end
        for (int c = 0; c < 4; c++) begin
            regs.dac_data[c] = ref_val[c];
            regs.dac_ctrl[c] = ref_val[4 + c];
            regs.gain[c] = ref_val[8 + c];
            regs.offset[c] = ref_val[12 + c];
            regs.clear_code[c] = ref_val[16 + c];
        end
        regs.status = ref_val[24];
        regs.main_ctrl = ref_val[25];
        regs.dcdc_ctrl = ref_val[26];
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        check({23'h0, pend}, 24'h0);
        check({8'h0, cfg[1:0]}, 24'h0);
        check({8'h0, cfg[3:2]}, 24'h0);
        // back-to-back slew writes, one per channel
        for (int c = 0; c < 4; c++) begin
            swr = '{1'b1, 2'(c), SW[c]};
            @(negedge clk);
        end
        swr = '0;
        @(negedge clk);
        for (int c = 0; c < 4; c++) begin
            check({16'h0, cfg[c]}, {16'h0, SW[c][12], SW[c][6:3], SW[c][2:0]});
        end
        // a slew write offered while the clock enable is low must not be taken
        en = 1'b0;
        swr = '{1'b1, 2'h0, 16'h0000};
        @(negedge clk);
        swr = '0;
        en = 1'b1;
        @(negedge clk);
        check({16'h0, cfg[0]}, {16'h0, SW[0][12], SW[0][6:3], SW[0][2:0]});
        // chained reads of codes 0 to 27, alternating first clock edge, junk in the low bits
        for (int k = 0; k < 28; k++) begin
            u_host.xfer({1'b1, 2'b01, 5'(k), 16'hbeef}, 1'(k % 2), rx);
            if (k == 0) begin
                check({23'h0, pend}, 24'h1);
            end else begin
                check(pick(rx, 1'(k % 2)), {8'h0, expect_of(k - 1)});
            end
        end
        u_host.xfer(24'h3ce000, 1'b1, rx);
        check(pick(rx, 1'b1), {8'h0, expect_of(27)});
        check({23'h0, pend}, 24'h0);
        check(24'(nvalid), 24'h0);
        // request to another device address
        u_host.xfer({1'b1, 2'b10, 5'd8, 16'h0000}, 1'b0, rx);
        check({23'h0, pend}, 24'h0);
        // ordinary write word, then a no-operation frame
        u_host.xfer(24'h312345, 1'b1, rx);
        check(24'(nvalid), 24'h1);
        check(last_word, 24'h312345);
        u_host.xfer(24'h3ce000, 1'b1, rx);
        check(pick(rx, 1'b1), 24'h0);
        check(24'(nvalid), 24'h1);
        // status returned on writes once the option is on
        soew = 1'b1;
        u_host.xfer(24'h312345, 1'b1, rx);
        u_host.xfer(24'h3ce000, 1'b1, rx);
        check(pick(rx, 1'b1), {8'h0, ref_val[24]});
        summarize();
    end
endmodule : serial_register_readback_tb
